/* design/sclk_rate_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module sclk_rate_gen (
	input wire logic  core_clk, // Bus clock
	input wire logic  sys_rst,  // Synchronous reset, high
	sclk_rate_if.gen  rif       // Rate control and half-period tick
);

	logic [15:0] cnt_q;
	logic [4:0]  half_q;
	logic        sel_q;
	logic [15:0] limit;

	// Each half period lasts divisor+1 bus clocks
	assign limit = (rif.var_en && sel_q) ? rif.div_b : rif.div_a;
	assign rif.half_tick = rif.run && (cnt_q == limit);

	always_ff @(posedge core_clk) begin
		if (sys_rst || !rif.run || rif.half_tick) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// Pattern is read MSB first, one bit per half, two per serial cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst || !rif.run) begin
			half_q <= 5'h00;
		end else if (rif.half_tick) begin
			half_q <= half_q + 5'h01;
		end
	end

	// The bit of the finished half picks the rate of the next one
	always_ff @(posedge core_clk) begin
		if (sys_rst || !rif.run) begin
			sel_q <= 1'b0;
		end else if (rif.half_tick) begin
			sel_q <= rif.pattern[~half_q];
		end
	end

endmodule // sclk_rate_gen
`default_nettype wire

/* design/sclk_rate_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface sclk_rate_if;
	logic        run;
	logic        var_en;
	logic [15:0] div_a;
	logic [15:0] div_b;
	logic [31:0] pattern;
	logic        half_tick;

	modport ctrl (output run, var_en, div_a, div_b, pattern, input half_tick);
	modport gen  (input run, var_en, div_a, div_b, pattern, output half_tick);
endinterface
`default_nettype wire

/* design/serial_peripheral_link_ctrl.sv */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Variable clock enable uses patterned clock rates
// - Pattern 0 picks divisor A, 1 divisor B
// - Two pattern bits per cycle, MSB first
// - Select polarity follows active level bit
// - Select input level or edge sensitive
// - Clock idles at idle polarity bit
// - Word length field sets bits per word
// - Separate bits choose drive and sample edge
// - Low bit first when flag set
// - Single word ignores gap length
// - Master run starts transfer, self clears
// - Slave run arms wait for master
// - Manual select follows select output bit
// - Completion raises interrupt when enabled
// - Receive word zero, transmit word zero
// - Two instances at separate base addresses
// - Completion flag clears on write one
// - Clock equals bus clock over 2(div+1)
// - Level select drop ends transfer, flags
module serial_peripheral_link_ctrl
	import spi_link_pkg::*;
#(
	parameter logic [31:0] BASE_ADDR = BASE_LINK0
) (
	input  wire logic        core_clk,      // Bus clock, 40 MHz
	input  wire logic        sys_rst,       // Synchronous reset, high
	input  wire logic [31:0] s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Write byte lanes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	input  wire logic [31:0] s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read data valid
	input  wire logic        s_axi_rready,  // Read data ready
	input  wire logic        sclk_in,       // Serial clock pin in
	output logic             sclk_out,      // Serial clock pin out
	output logic             sclk_oe,       // Serial clock drive enable
	input  wire logic        select_in,     // Select pin in
	output logic             select_out,    // Select pin out
	output logic             select_oe,     // Select drive enable
	input  wire logic        data_in,       // Serial data in
	output logic             data_out,      // Serial data out
	output logic             irq            // Completion interrupt
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [31:0] div_q;
	logic [31:0] ssr_q;
	logic [31:0] pat_q;
	logic [31:0] tx_q [2];
	logic [31:0] rx_q [2];
	logic        busy_q;
	logic        flag_q;
	logic        met_q;

	xfer_state_t st_q;
	logic [7:0]  hc_q;
	logic [5:0]  drv_k_q;
	logic [5:0]  smp_k_q;
	logic        word_q;
	logic        ph_q;
	logic        dout_q;
	logic        sclk_prev_q;
	logic        act_prev_q;

	logic        aw_hold_q;
	logic        w_hold_q;
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	sclk_rate_if rif ();

	sclk_rate_gen u_rate (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.rif      (rif.gen)
	);

	function automatic logic addr_hit(input logic [31:0] a);
		logic [7:0] o;
		o = a[7:0];
		if (a[31:14] != BASE_ADDR[31:14] || a[13:8] != 6'h00) begin
			return 1'b0;
		end else if (o == OFF_CTRL || o == OFF_DIV || o == OFF_SEL || o == OFF_PAT) begin
			return 1'b1;
		end else if (o == OFF_RX0 || o == OFF_RX1 || o == OFF_TX0 || o == OFF_TX1) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic       do_wr;
	logic       wr_ok;
	logic       cfg_ok;
	logic [7:0] w_off;
	logic       wr_ctrl;
	logic       run_wr;
	logic       go;
	logic       stop;
	logic       flag_clr;

	assign do_wr    = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_ok    = do_wr && addr_hit(aw_addr_q);
	assign w_off    = aw_addr_q[7:0];
	// Mid-transfer register stores are dropped so settings cannot change under the shifter; CTRL run and flag bits still act
	assign cfg_ok   = wr_ok && !busy_q;
	assign wr_ctrl  = wr_ok && (w_off == OFF_CTRL);
	assign run_wr   = wr_ctrl && w_strb_q[0];
	assign go       = run_wr && w_data_q[CB_RUN] && !busy_q;
	assign stop     = run_wr && !w_data_q[CB_RUN] && busy_q;
	assign flag_clr = wr_ctrl && w_strb_q[2] && w_data_q[CB_FLAG];

	// ----------------------------------------------------------------
	// Transfer decode
	// ----------------------------------------------------------------
	logic       slave;
	logic       lsb;
	logic       cpol;
	logic       two;
	logic       more;
	logic [5:0] n_bits;
	logic [7:0] gap_halves;
	logic [4:0] gap_periods;
	logic       s_active;
	logic       lvl_mode;
	logic       shifting;
	logic       tick;
	logic       edge_e;
	logic       rise_e;
	logic       drive_e;
	logic       sample_e;
	logic       m_word_end;
	logic       s_word_end;
	logic       word_end;
	logic       gap_end;
	logic       s_start;
	logic       s_drop;
	logic       done;

	assign slave       = ctrl_q[CB_SLAVE];
	assign lsb         = ctrl_q[CB_LSB];
	assign cpol        = ctrl_q[CB_CPOL];
	assign n_bits      = word_bits(ctrl_q[7:3]);
	assign two         = (ctrl_q[9:8] == 2'b01);
	assign more        = two && !word_q;
	assign gap_periods = {1'b0, ctrl_q[15:12]} + GAP_BASE;
	assign gap_halves  = {2'b00, gap_periods, 1'b0};
	assign s_active    = (select_in == ssr_q[SB_LEVEL]);
	assign lvl_mode    = ssr_q[SB_LSENS];
	assign shifting    = (st_q == ST_SHIFT);
	assign tick        = rif.half_tick;

	assign rif.run     = !slave && (st_q != ST_IDLE);
	assign rif.var_en  = ctrl_q[CB_VAR];
	assign rif.div_a   = div_q[15:0];
	assign rif.div_b   = div_q[31:16];
	assign rif.pattern = pat_q;

	// Slave clock is sampled on the bus clock, hence the five-period floor
	always_comb begin
		if (slave) begin
			edge_e = shifting && s_active && !met_q && (sclk_in != sclk_prev_q);
			rise_e = sclk_in;
		end else begin
			edge_e = shifting && tick;
			rise_e = !(ph_q ^ cpol);
		end
	end

	assign drive_e    = edge_e && (rise_e ^ ctrl_q[CB_DRIVE_FALL]);
	assign sample_e   = edge_e && (rise_e ^ ctrl_q[CB_SAMPLE_FALL]);
	assign m_word_end = !slave && shifting && tick
		&& (hc_q == {1'b0, n_bits, 1'b0} - 8'h01);
	assign s_word_end = slave && sample_e && (smp_k_q == n_bits - 6'h01);
	assign word_end   = m_word_end || s_word_end;
	assign gap_end    = (st_q == ST_GAP) && tick && (hc_q == gap_halves - 8'h01);
	assign s_start    = slave && busy_q && (st_q == ST_IDLE) && s_active
		&& (lvl_mode || !act_prev_q);
	assign s_drop     = slave && shifting && !s_active && (lvl_mode || act_prev_q);

	always_comb begin
		done = 1'b0;
		if (!slave && m_word_end && !more) begin
			done = 1'b1;
		end else if (s_drop) begin
			done = 1'b1;
		end else if (slave && lvl_mode && s_word_end && !more) begin
			done = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst || stop) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if ((go && !slave) || s_start) begin
						st_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (done) begin
						st_q <= ST_IDLE;
					end else if (m_word_end && more) begin
						st_q <= ST_GAP;
					end
				end
				ST_GAP: begin
					if (gap_end) begin
						st_q <= ST_SHIFT;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || st_q == ST_IDLE || m_word_end || gap_end) begin
			hc_q <= 8'h00;
		end else if (tick) begin
			hc_q <= hc_q + 8'h01;
		end
	end

	// Drive index trails the sample index so the first bit is not skipped
	always_ff @(posedge core_clk) begin
		if (sys_rst || st_q == ST_IDLE || word_end) begin
			smp_k_q <= 6'h00;
			drv_k_q <= 6'h00;
		end else begin
			if (sample_e) begin
				smp_k_q <= smp_k_q + 6'h01;
			end
			if (drive_e && smp_k_q != 6'h00) begin
				drv_k_q <= drv_k_q + 6'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || st_q == ST_IDLE) begin
			word_q <= 1'b0;
		end else if (word_end && more) begin
			word_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || !shifting || slave) begin
			ph_q <= 1'b0;
		end else if (tick) begin
			ph_q <= !ph_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sclk_prev_q <= 1'b0;
			act_prev_q  <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_in;
			act_prev_q  <= s_active;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dout_q <= 1'b0;
		end else begin
			dout_q <= tx_q[word_q][bit_index(drv_k_q, n_bits, lsb)];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_q[0] <= 32'h0000_0000;
			rx_q[1] <= 32'h0000_0000;
		end else if (sample_e) begin
			rx_q[word_q][bit_index(smp_k_q, n_bits, lsb)] <= data_in;
		end
	end

	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
		end else if (go) begin
			busy_q <= 1'b1;
		end else if (done || stop) begin
			busy_q <= 1'b0;
		end
	end

	// A completion in the clearing cycle keeps the flag set
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_q <= 1'b0;
		end else if (done) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || go) begin
			met_q <= 1'b0;
		end else if (word_end && !more) begin
			met_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RESET;
			div_q  <= DIV_RESET;
			ssr_q  <= SEL_RESET;
			pat_q  <= PAT_RESET;
		end else if (cfg_ok) begin
			if (w_off == OFF_CTRL) begin
				ctrl_q <= merge_bytes(ctrl_q, w_data_q, w_strb_q) & CTRL_WMASK;
			end else if (w_off == OFF_DIV) begin
				div_q <= merge_bytes(div_q, w_data_q, w_strb_q);
			end else if (w_off == OFF_SEL) begin
				ssr_q <= merge_bytes(ssr_q, w_data_q, w_strb_q) & SEL_WMASK;
			end else if (w_off == OFF_PAT) begin
				pat_q <= merge_bytes(pat_q, w_data_q, w_strb_q);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_q[0] <= 32'h0000_0000;
			tx_q[1] <= 32'h0000_0000;
		end else if (cfg_ok) begin
			if (w_off == OFF_TX0) begin
				tx_q[0] <= merge_bytes(tx_q[0], w_data_q, w_strb_q);
			end else if (w_off == OFF_TX1) begin
				tx_q[1] <= merge_bytes(tx_q[1], w_data_q, w_strb_q);
			end
		end
	end

	// ----------------------------------------------------------------
	// Pins and interrupt
	// ----------------------------------------------------------------
	logic sel_act;

	// Auto select asserts only while busy; manual mode follows the bit
	assign sel_act    = ssr_q[SB_AUTO] ? (busy_q && ssr_q[SB_OUT]) : ssr_q[SB_OUT];
	assign select_out = sel_act ? ssr_q[SB_LEVEL] : !ssr_q[SB_LEVEL];
	assign select_oe  = !slave;
	assign sclk_out   = ph_q ^ cpol;
	assign sclk_oe    = !slave;
	assign data_out   = dout_q;
	assign irq        = flag_q && ctrl_q[CB_IRQ_EN];

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst || do_wr) begin
			aw_hold_q <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			aw_addr_q <= 32'h0000_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_addr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || do_wr) begin
			w_hold_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_ok ? RESP_OKAY : RESP_ERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	logic [31:0] rd_val;
	logic [7:0]  r_off;

	assign r_off         = s_axi_araddr[7:0];
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_comb begin
		rd_val = 32'h0000_0000;
		if (!addr_hit(s_axi_araddr)) begin
			rd_val = 32'h0000_0000;
		end else if (r_off == OFF_CTRL) begin
			rd_val = ctrl_q;
			rd_val[CB_RUN]  = busy_q;
			rd_val[CB_FLAG] = flag_q;
		end else if (r_off == OFF_DIV) begin
			rd_val = div_q;
		end else if (r_off == OFF_SEL) begin
			rd_val = ssr_q;
			rd_val[SB_MET] = met_q;
		end else if (r_off == OFF_RX0) begin
			rd_val = rx_q[0];
		end else if (r_off == OFF_RX1) begin
			rd_val = rx_q[1];
		end else if (r_off == OFF_PAT) begin
			rd_val = pat_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_val;
			rresp_q  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_ERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule // serial_peripheral_link_ctrl
`default_nettype wire

/* design/spi_link_pkg.sv */
`default_nettype none
package spi_link_pkg;

	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam logic [31:0] BASE_LINK0  = 32'h4003_0000;
	localparam logic [31:0] BASE_LINK1  = 32'h4003_4000;
	localparam logic [7:0]  OFF_CTRL    = 8'h00;
	localparam logic [7:0]  OFF_DIV     = 8'h04;
	localparam logic [7:0]  OFF_SEL     = 8'h08;
	localparam logic [7:0]  OFF_RX0     = 8'h10;
	localparam logic [7:0]  OFF_RX1     = 8'h14;
	localparam logic [7:0]  OFF_TX0     = 8'h20;
	localparam logic [7:0]  OFF_TX1     = 8'h24;
	localparam logic [7:0]  OFF_PAT     = 8'h34;

	localparam logic [31:0] CTRL_RESET  = 32'h0000_0004;
	localparam logic [31:0] CTRL_WMASK  = 32'h009E_FFFE;
	localparam logic [31:0] DIV_RESET   = 32'h0000_0000;
	localparam logic [31:0] SEL_RESET   = 32'h0000_0000;
	localparam logic [31:0] SEL_WMASK   = 32'h0000_001D;
	localparam logic [31:0] PAT_RESET   = 32'h007F_FF87;

	localparam int CB_RUN         = 0;
	localparam int CB_SAMPLE_FALL = 1;
	localparam int CB_DRIVE_FALL  = 2;
	localparam int CB_LSB         = 10;
	localparam int CB_CPOL        = 11;
	localparam int CB_FLAG        = 16;
	localparam int CB_IRQ_EN      = 17;
	localparam int CB_SLAVE       = 18;
	localparam int CB_VAR         = 23;
	localparam int SB_OUT         = 0;
	localparam int SB_LEVEL       = 2;
	localparam int SB_AUTO        = 3;
	localparam int SB_LSENS       = 4;
	localparam int SB_MET         = 5;

	localparam logic [4:0] GAP_BASE   = 5'h02;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_ERR   = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_GAP   = 2'b11
	} xfer_state_t;

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	function automatic logic [5:0] word_bits(input logic [4:0] len);
		return (len == 5'h00) ? 6'h20 : {1'b0, len};
	endfunction

	function automatic logic [4:0] bit_index(input logic [5:0] k, input logic [5:0] n,
		input logic lsb);
		logic [5:0] m;
		m = n - 6'h01 - k;
		return lsb ? k[4:0] : m[4:0];
	endfunction

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage
`default_nettype wire

/* test/serial_peripheral_link_ctrl_props.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_peripheral_link_ctrl_props
	import spi_link_pkg::*;
(
	input wire logic	core_clk,	// Bus clock
	input wire logic	sys_rst,	// Reset, high
	input wire logic	s_axi_awvalid,	// AW valid
	input wire logic	s_axi_awready,	// AW ready
	input wire logic	s_axi_wvalid,	// W valid
	input wire logic	s_axi_wready,	// W ready
	input wire logic [1:0]	s_axi_bresp,	// B code
	input wire logic	s_axi_bvalid,	// B valid
	input wire logic	s_axi_bready,	// B ready
	input wire logic [31:0]	s_axi_araddr,	// AR address
	input wire logic	s_axi_arvalid,	// AR valid
	input wire logic	s_axi_arready,	// AR ready
	input wire logic [31:0]	s_axi_rdata,	// R data
	input wire logic [1:0]	s_axi_rresp,	// R code
	input wire logic	s_axi_rvalid,	// R valid
	input wire logic	s_axi_rready,	// R ready
	input wire logic	sclk_oe,	// Clock drive enable
	input wire logic	select_oe	// Select drive enable
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	// ----------------------------------------------------------------
	// Register bus handshakes
	// ----------------------------------------------------------------
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
	a_write_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_stall: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_unmapped_err: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr[13:8] != 6'h00 |=>
		s_axi_rresp == RESP_ERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
	// Both pins change direction together with the mode bit
	a_mode_pair: assert property (sclk_oe == select_oe) else $error("pin enables disagree");
endmodule // serial_peripheral_link_ctrl_props
bind serial_peripheral_link_ctrl serial_peripheral_link_ctrl_props i_props (.*);
`default_nettype wire

/* test/spi_far_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_far_slave (
	input wire logic	sclk,	// Clock from master
	input wire logic	sel,	// Select, active high here
	input wire logic	mosi,	// Data from master
	input wire logic [31:0]	load,	// Word to send
	input wire logic [5:0]	n,	// Bits per word
	output logic	miso,	// Data to master
	output logic [31:0]	got	// Received bits, line order
);
	int	k;
	// A new word restarts the shift, high bit first
	always @(posedge sel or load) begin
		k = 0;
		got = 32'h0;
		miso = load[n - 6'h01];
	end
	always @(posedge sclk) if (sel) got = {got[30:0], mosi};
	always @(negedge sclk) if (sel && k < n - 1) begin
		k++;
		miso = load[n - 1 - k];
	end
	// Released line shows the inverse, so a stale bit cannot pass
	always @(negedge sel) miso = ~miso;
endmodule // spi_far_slave
`default_nettype wire

/* test/test_serial_peripheral_link_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module test_serial_peripheral_link_ctrl;
	import spi_link_pkg::*;
	logic	core_clk = 1'b0, sys_rst = 1'b1;
	logic [31:0]	s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, far = '0;
	logic [3:0]	s_axi_wstrb = 4'hF;
	logic	s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic	s_axi_arvalid = 0, s_axi_rready = 0, sclk_in = 0, select_in = 1;
	logic	s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic [31:0]	s_axi_rdata, got;
	logic	data_in, sclk_out, sclk_oe, select_out, select_oe, data_out, irq;
	logic [5:0]	n = 6'd8;
	logic [63:0]	expq[$], ex;
	int	errors = 0, samples_checked = 0, hi = 0;
	wire logic	sel = !select_out;

	serial_peripheral_link_ctrl i_dut (.*);
	spi_far_slave i_far (.sclk(sclk_out), .sel(sel), .mosi(data_out), .load(far), .n(n),
		.miso(data_in), .got(got));

	initial forever #12.5 core_clk = ~core_clk;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] ad(input logic [7:0] o);
		return {BASE_LINK0[31:8], o};
	endfunction
	function automatic logic [31:0] rev(input logic [31:0] v, input logic [5:0] w);
		logic [31:0] r = '0;
		for (int i = 0; i < w; i++) r[i] = v[w - 1 - i];
		return r;
	endfunction
	task automatic wr(input logic [7:0] o, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		s_axi_awaddr <= ad(o);
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (i == 200) begin
			errors++;
			give_verdict();
		end
	endtask
	// Mask zero marks a poll whose value is not compared
	task automatic rd(input logic [31:0] a, e, m, output logic [31:0] d);
		int i;
		expq.push_back({e, m});
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				break;
			end
		end
		s_axi_rready <= 1'b0;
		if (i == 200) begin
			errors++;
			give_verdict();
		end
	endtask
	always @(posedge core_clk) begin
		if (s_axi_rvalid && s_axi_rready && expq.size() > 0) begin
			ex = expq.pop_front();
			if (ex[31:0] != 32'h0) chk(s_axi_rdata & ex[31:0], ex[63:32]);
		end
	end
	// Bus clocks spent with the serial clock high, to measure half periods
	always @(posedge core_clk) if (sclk_out) hi++;
	task automatic xfer(input logic [31:0] c, input logic [5:0] w, input logic [31:0] tx);
		logic [31:0] d, m;
		int i;
		m = (w == 6'd32) ? '1 : (32'h1 << w) - 32'h1;
		n = w;
		far = $urandom();
		wr(OFF_TX0, tx);
		wr(OFF_CTRL, c | 32'h1);
		for (i = 0; i < 400; i++) begin
			rd(ad(OFF_CTRL), 32'h0, 32'h0, d);
			if (d[0] === 1'b0) break;
		end
		chk(i < 400, 1);
		rd(ad(OFF_RX0), c[10] ? rev(far, w) : far & m, m, d);
		chk(got & m, c[10] ? rev(tx, w) : tx & m);
		chk({31'h0, irq}, {31'h0, c[17]});
		$display("transfer of %0d bits done", w);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		d = $urandom(32'h1377b365);
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(ad(OFF_CTRL), CTRL_RESET, '1, d);
		rd(ad(OFF_PAT), PAT_RESET, '1, d);
		rd(ad(OFF_DIV), DIV_RESET, '1, d);
		rd(ad(OFF_SEL), SEL_RESET, '1, d);
		rd(ad(OFF_TX0), 32'h0, '1, d);
		rd(BASE_LINK0 + 32'h0000_010C, 32'h0, '1, d);
		$display("reset values done");
		wr(OFF_DIV, 32'h0000_0001);
		wr(OFF_SEL, 32'h0000_0001);
		chk({31'h0, select_out}, 32'h0);
		xfer(32'h0002_0044, 6'd8, $urandom());
		rd(ad(OFF_CTRL), 32'h0001_0000, 32'h0001_0001, d);
		wr(OFF_CTRL, 32'h0002_0044);
		chk({31'h0, irq}, 32'h1);
		wr(OFF_CTRL, 32'h0003_0044);
		chk({31'h0, irq}, 32'h0);
		xfer(32'h0000_0484, 6'd16, $urandom());
		xfer(32'h0000_0044, 6'd8, 32'h0000_00FF);
		xfer(32'h0000_0004, 6'd32, $urandom());
		wr(OFF_DIV, 32'h0002_0001);
		wr(OFF_PAT, 32'hFFFF_0000);
		d = hi;
		xfer(32'h0080_0084, 6'd16, $urandom());
		// High halves: eight of three clocks, then eight of two
		chk(hi - d, 32'd40);
		select_in <= 1'b0;
		wr(OFF_SEL, 32'h0000_0014);
		wr(OFF_CTRL, 32'h0005_0044);
		wr(OFF_CTRL, 32'h0004_0045);
		rd(ad(OFF_CTRL), 32'h0004_0045, '1, d);
		select_in <= 1'b1;
		repeat (6) begin
			repeat (3) @(posedge core_clk);
			sclk_in <= ~sclk_in;
		end
		select_in <= 1'b0;
		repeat (3) @(posedge core_clk);
		rd(ad(OFF_CTRL), 32'h0005_0044, '1, d);
		rd(ad(OFF_SEL), 32'h0000_0014, '1, d);
		$display("slave drop done");
		wr(OFF_CTRL, 32'h0000_0800);
		chk({31'h0, sclk_out}, 32'h1);
		wr(OFF_CTRL, 32'h0);
		chk({31'h0, sclk_out}, 32'h0);
		wr(OFF_SEL, 32'h0000_0005);
		chk({31'h0, select_out}, 32'h1);
		wr(OFF_SEL, 32'h0000_0004);
		chk({31'h0, select_out}, 32'h0);
		$display("pin levels done");
		give_verdict();
	end
endmodule // test_serial_peripheral_link_ctrl
`default_nettype wire
